// [design/pci_tgt_pkg.sv]
// Shared constants for the single-phase expansion bus target.
// Assumes the bus clock and reset are common to every user of it.
package pci_tgt_pkg;

	// ------------------------------------------------------------
	// Bus commands, as seen on the command/byte-enable lines
	// ------------------------------------------------------------
	localparam logic [3:0] CMD_IO_RD = 4'h2;
	localparam logic [3:0] CMD_IO_WR = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
	localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
	localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;

	// ------------------------------------------------------------
	// Address spaces, field positions and reset values
	// ------------------------------------------------------------
	localparam logic [1:0] SPACE_CFG = 2'h0;
	localparam logic [1:0] SPACE_IO = 2'h1;
	localparam logic [1:0] SPACE_MEM = 2'h2;
	localparam int CMD_WRITE_BIT = 0;
	localparam logic CTL_RESET = 1'h1;
	localparam logic OE_RESET = 1'h0;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// ------------------------------------------------------------
	// Target sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE, ST_CLAIM, ST_CHECK, ST_DATA, ST_DISC, ST_ABORT, ST_TURN
	} tgt_state_type;

endpackage

// [design/be_check.sv]
// Byte-enable versus low address bit consistency check.
// Assumes byte enables are active low, as on the bus.
`timescale 1ns/1ps
`default_nettype none
module be_check (
	input wire logic [1:0] addr_lo_in, // Address bits 1:0.
	input wire logic [3:0] be_n_in, // Active low byte enables.
	output logic match_out // High when the pair is legal.
);

	// The addressed byte must be enabled and all lower bytes disabled.
	always_comb begin
		case (addr_lo_in)
		2'h0: begin
			match_out = !be_n_in[0];
		end
		2'h1: begin
			match_out = !be_n_in[1] && be_n_in[0];
		end
		2'h2: begin
			match_out = !be_n_in[2] && (&be_n_in[1:0]);
		end
		default: begin
			match_out = !be_n_in[3] && (&be_n_in[2:0]);
		end
		endcase
	end

endmodule
`default_nettype wire

// [design/parity_unit.sv]
// Even parity generation and checking over data and command lines.
// Assumes the bus presents data one clock ahead of its parity bit.
`timescale 1ns/1ps
`default_nettype none
module parity_unit (
	input wire logic sys_clk_in, // Bus clock.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic [31:0] ad_in, // Address/data lines as sampled.
	input wire logic [3:0] cbe_n_in, // Command/byte-enable lines.
	input wire logic [31:0] ad_drv_in, // Data that the target drives.
	input wire logic ad_drv_en_in, // High while the target drives data.
	input wire logic par_in, // Parity line as sampled.
	input wire logic chk_addr_in, // This cycle is an address phase.
	input wire logic chk_data_in, // This cycle moves write data.
	output logic par_out, // Generated parity bit.
	output logic par_oe_out, // Parity drive enable.
	output logic addr_err_out, // Address parity error pulse.
	output logic data_err_out // Data parity error pulse.
);

	logic expect_par;
	logic chk_addr_q;
	logic chk_data_q;
	wire logic sample_par = ^{ad_in, cbe_n_in};
	wire logic drive_par = ^{ad_drv_in, cbe_n_in};
	wire logic mismatch = expect_par != par_in;

	// Parity follows its data by one clock, both ways.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			expect_par <= 1'h0;
			chk_addr_q <= 1'h0;
			chk_data_q <= 1'h0;
			par_out <= 1'h0;
			par_oe_out <= 1'h0;
			addr_err_out <= 1'h0;
			data_err_out <= 1'h0;
		end else begin
			expect_par <= sample_par;
			chk_addr_q <= chk_addr_in;
			chk_data_q <= chk_data_in;
			par_out <= drive_par;
			par_oe_out <= ad_drv_en_in;
			addr_err_out <= chk_addr_q && mismatch;
			data_err_out <= chk_data_q && mismatch;
		end
	end

endmodule
`default_nettype wire

// [design/pci_target.sv]
// Single data phase bus target with disconnect and target-abort.
// Assumes all bus inputs are synchronous to sys_clk_in and that the
// user side answers reads combinationally from the latched address.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - IDSEL with config command selects configuration space
// - Target only, never starts bus transactions
// - Burst: finish first phase, then assert stop
// - No data moves after stop asserted
// - Target-abort drops devsel together with stop
// - Devsel held a clock, trdy off, before abort
// - Address parity error raises system error, aborts
// - Low address bits must match byte enables; checked only for I/O space
// - Byte-enable mismatch: no data, target-abort
// - Accept back-to-back transaction without idle cycle
// - Parity driven one clock after its data
// - Parity spans all data and command lines
// - Parity makes total count of ones even
// - Configuration cycles also generate and check parity
// - Only one data phase per transaction
module pci_target
	import pci_tgt_pkg::*;
#(
	parameter logic [31:0] IO_BASE = 32'h0000_0300,
	parameter int IO_ADDR_BITS = 5,
	parameter logic [31:0] MEM_BASE = 32'h000d_0000,
	parameter int MEM_ADDR_BITS = 14
) (
	input wire logic sys_clk_in, // Bus clock.
	input wire logic rst_in, // Synchronous reset, active high.
	input wire logic frame_n_in, // Cycle frame, active low.
	input wire logic irdy_n_in, // Initiator ready, active low.
	input wire logic idsel_in, // Configuration select.
	input wire logic [31:0] ad_in, // Address/data lines sampled.
	input wire logic [3:0] cbe_n_in, // Command/byte enables.
	input wire logic par_in, // Parity line sampled.
	input wire logic [31:0] rdata_in, // Read data from user side.
	output logic [31:0] ad_out, // Read data driven to the bus.
	output logic ad_oe_out, // Address/data drive enable.
	output logic par_out, // Parity driven to the bus.
	output logic par_oe_out, // Parity drive enable.
	output logic devsel_n_out, // Device select, active low.
	output logic trdy_n_out, // Target ready, active low.
	output logic stop_n_out, // Stop, active low.
	output logic ctl_oe_out, // Enable for devsel, trdy, stop.
	output logic perr_int_out, // Data parity error pulse.
	output logic serr_int_out, // Address parity error pulse.
	output logic acc_strobe_out, // Data phase completed pulse.
	output logic acc_write_out, // Access is a write.
	output logic [1:0] acc_space_out, // Address space of access.
	output logic [31:0] acc_addr_out, // Latched address.
	output logic [3:0] acc_be_n_out, // Latched byte enables.
	output logic [31:0] acc_wdata_out // Latched write data.
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	tgt_state_type state;
	tgt_state_type next_state;
	logic frame_q;
	logic next_devsel_n;
	logic next_trdy_n;
	logic next_stop_n;
	logic next_ctl_oe;
	logic next_ad_oe;
	logic be_ok;
	logic addr_err;

	// Address phase is the first clock with frame asserted.
	wire logic new_addr = !frame_n_in && frame_q;
	wire logic [3:0] cmd = cbe_n_in;
	wire logic cfg_cmd = cmd == CMD_CFG_RD || cmd == CMD_CFG_WR;
	wire logic io_cmd = cmd == CMD_IO_RD || cmd == CMD_IO_WR;
	wire logic mem_cmd = cmd == CMD_MEM_RD || cmd == CMD_MEM_WR ||
		cmd == CMD_MEM_RD_MULT || cmd == CMD_MEM_RD_LINE ||
		cmd == CMD_MEM_WR_INV;
	wire logic io_match = (ad_in >> IO_ADDR_BITS) ==
		(IO_BASE >> IO_ADDR_BITS);
	wire logic mem_match = (ad_in >> MEM_ADDR_BITS) ==
		(MEM_BASE >> MEM_ADDR_BITS);
	wire logic cfg_hit = idsel_in && cfg_cmd;
	wire logic io_hit = io_cmd && io_match;
	wire logic mem_hit = mem_cmd && mem_match;
	wire logic hit = cfg_hit || io_hit || mem_hit;
	wire logic can_start = state == ST_IDLE || state == ST_TURN;
	wire logic start = can_start && new_addr && hit;
	wire logic [1:0] hit_space = cfg_hit ? SPACE_CFG :
		(io_hit ? SPACE_IO : SPACE_MEM);
	wire logic xfer = state == ST_DATA && !irdy_n_in;
	wire logic be_bad = acc_space_out == SPACE_IO && !be_ok;
	wire logic chk_data = xfer && acc_write_out;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Byte enables are checked against the latched low address bits.
	be_check u_be_check (
		.addr_lo_in(acc_addr_out[1:0]),
		.be_n_in(acc_be_n_out),
		.match_out(be_ok)
	);

	// Parity covers every access type, configuration included.
	parity_unit u_parity (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ad_in(ad_in),
		.cbe_n_in(cbe_n_in),
		.ad_drv_in(ad_out),
		.ad_drv_en_in(ad_oe_out),
		.par_in(par_in),
		.chk_addr_in(start),
		.chk_data_in(chk_data),
		.par_out(par_out),
		.par_oe_out(par_oe_out),
		.addr_err_out(addr_err),
		.data_err_out(perr_int_out)
	);

	assign serr_int_out = addr_err;

	// ------------------------------------------------------------
	// Target sequencer
	// ------------------------------------------------------------
	// The device never drives frame or irdy; it only answers.
	always_comb begin
		next_state = state;
		next_devsel_n = devsel_n_out;
		next_trdy_n = trdy_n_out;
		next_stop_n = stop_n_out;
		next_ctl_oe = ctl_oe_out;
		next_ad_oe = ad_oe_out;
		case (state)
		ST_IDLE, ST_TURN: begin
			next_state = ST_IDLE;
			next_ctl_oe = 1'h0;
			next_ad_oe = 1'h0;
			if (start) begin
				next_state = ST_CLAIM;
				next_devsel_n = 1'h0;
				next_ctl_oe = 1'h1;
			end
		end
		ST_CLAIM: begin
			next_state = ST_CHECK;
		end
		ST_CHECK: begin
			if (addr_err || be_bad) begin
				next_state = ST_ABORT;
				next_devsel_n = 1'h1;
				next_stop_n = 1'h0;
			end else begin
				next_state = ST_DATA;
				next_trdy_n = 1'h0;
				next_ad_oe = !acc_write_out;
			end
		end
		ST_DATA: begin
			if (!irdy_n_in) begin
				next_trdy_n = 1'h1;
				next_ad_oe = 1'h0;
				if (!frame_n_in) begin
					next_state = ST_DISC;
					next_stop_n = 1'h0;
				end else begin
					next_state = ST_TURN;
					next_devsel_n = 1'h1;
				end
			end
		end
		ST_DISC, ST_ABORT: begin
			if (frame_n_in) begin
				next_state = ST_TURN;
				next_stop_n = 1'h1;
				next_devsel_n = 1'h1;
			end
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	// Sequencer and bus control registers.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			frame_q <= CTL_RESET;
			devsel_n_out <= CTL_RESET;
			trdy_n_out <= CTL_RESET;
			stop_n_out <= CTL_RESET;
			ctl_oe_out <= OE_RESET;
			ad_oe_out <= OE_RESET;
		end else begin
			state <= next_state;
			frame_q <= frame_n_in;
			devsel_n_out <= next_devsel_n;
			trdy_n_out <= next_trdy_n;
			stop_n_out <= next_stop_n;
			ctl_oe_out <= next_ctl_oe;
			ad_oe_out <= next_ad_oe;
		end
	end

	// ------------------------------------------------------------
	// User side access latches
	// ------------------------------------------------------------
	// Address, space and direction are caught in the address phase.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			acc_addr_out <= DATA_RESET;
			acc_space_out <= SPACE_CFG;
			acc_write_out <= 1'h0;
		end else if (start) begin
			acc_addr_out <= ad_in;
			acc_space_out <= hit_space;
			acc_write_out <= cmd[CMD_WRITE_BIT];
		end
	end

	// Byte enables in the first data clock, write data on transfer.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			acc_be_n_out <= 4'hf;
			acc_wdata_out <= DATA_RESET;
		end else if (state == ST_CLAIM || xfer) begin
			acc_be_n_out <= cbe_n_in;
			if (xfer && acc_write_out) begin
				acc_wdata_out <= ad_in;
			end
		end
	end

	// Read data is captured as the single data phase opens.
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			ad_out <= DATA_RESET;
			acc_strobe_out <= 1'h0;
		end else begin
			if (state == ST_CHECK) begin
				ad_out <= rdata_in;
			end
			acc_strobe_out <= xfer;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);

	wire logic bus_xor = ^{ad_out, cbe_n_in};

	sequence seq_abort;
		!stop_n_out && devsel_n_out && trdy_n_out && ctl_oe_out;
	endsequence

	sequence seq_claimed;
		!devsel_n_out && ctl_oe_out;
	endsequence

	chk_cfg_claim: assert property (
		(can_start && new_addr && idsel_in && cfg_cmd) |=>
		seq_claimed ##1 seq_claimed)
		else $error("configuration access not claimed");

	chk_burst_stop: assert property (
		(xfer && !frame_n_in) |=> !stop_n_out && trdy_n_out &&
		!devsel_n_out)
		else $error("burst not disconnected after first phase");

	chk_stop_nodata: assert property (
		(!stop_n_out && ctl_oe_out) |-> trdy_n_out && !ad_oe_out)
		else $error("data offered while stop asserted");

	chk_abort_devsel: assert property (
		($fell(stop_n_out) && devsel_n_out) |->
		$past(devsel_n_out, 1) == 1'h0)
		else $error("abort did not drop devsel with stop");

	chk_abort_order: assert property (
		(state == ST_CHECK && (addr_err || be_bad)) |->
		$past(!devsel_n_out && trdy_n_out) ##0 seq_claimed ##1 seq_abort)
		else $error("abort sequencing broken");

	chk_addr_par: assert property (
		serr_int_out |=> seq_abort)
		else $error("address parity error without abort");

	chk_be_abort: assert property (
		(state == ST_CHECK && be_bad) |=> seq_abort ##1
		!acc_strobe_out)
		else $error("byte-enable mismatch not aborted");

	chk_b2b_accept: assert property (
		(state == ST_TURN && new_addr && hit) |=> seq_claimed)
		else $error("back-to-back transaction refused");

	chk_par_timing: assert property (
		ad_oe_out |=> par_oe_out && par_out == $past(bus_xor))
		else $error("parity not driven one clock after data");

	chk_single_phase: assert property (
		acc_strobe_out |-> !$past(acc_strobe_out) ##1
		!acc_strobe_out)
		else $error("more than one data phase completed");

endmodule
`default_nettype wire

// [testbench/bus_master.sv]
// Bus master model that starts single, burst and faulty transfers.
// Assumes the bench resolves the shared address/data and parity lines.
`timescale 1ns/1ps
`default_nettype none
module bus_master (
	input wire logic clk_in, // Bus clock.
	input wire logic [31:0] ad_in, // Resolved address/data lines.
	input wire logic trdy_n_in, // Target ready, active low.
	input wire logic stop_n_in, // Stop request, active low.
	output logic frame_n_out, // Cycle frame, active low.
	output logic irdy_n_out, // Initiator ready, active low.
	output logic idsel_out, // Configuration select.
	output logic [31:0] ad_out, // Address or write data.
	output logic [3:0] cbe_n_out, // Command or byte enables.
	output logic par_out // Parity that the master drives.
);
	// Quiet bus at time zero.
	initial begin
		frame_n_out = 1'b1;
		irdy_n_out = 1'b1;
		idsel_out = 1'b0;
		ad_out = 32'h0;
		cbe_n_out = 4'hf;
		par_out = 1'b0;
	end

	// Released lines flip so that a stale value is never mistaken.
	// Parity stays one more clock, since it covers the last data phase.
	task automatic idle(input int n);
		ad_out = ~ad_out;
		cbe_n_out = ~cbe_n_out;
		@(posedge clk_in);
		#2;
		par_out = ~par_out;
		repeat (n - 1) @(posedge clk_in);
		#2;
	endtask

	// One transaction; how is 0 for no answer, 1 for data, 2 for stop.
	task automatic run(input logic [3:0] cmd, input logic [31:0] addr,
		input logic [3:0] be_n, input logic [31:0] wd, input logic sel,
		input logic bad_ap, input logic bad_dp, input logic burst,
		output logic [31:0] rd, output logic [1:0] how);
		int n;
		how = 2'h0;
		rd = 32'h0;
		frame_n_out = 1'b0;
		ad_out = addr;
		cbe_n_out = cmd;
		idsel_out = sel;
		@(posedge clk_in);
		#2;
		par_out = ^{addr, cmd} ^ bad_ap;
		idsel_out = 1'b0;
		irdy_n_out = 1'b0;
		frame_n_out = !burst;
		cbe_n_out = be_n;
		ad_out = cmd[0] ? wd : ~addr;
		n = 0;
		while (how == 2'h0 && n < 8) begin
			@(posedge clk_in);
			n++;
			if (!trdy_n_in) begin
				how = 2'h1;
				rd = ad_in;
			end else if (!stop_n_in) begin
				how = 2'h2;
			end
		end
		#2;
		par_out = cmd[0] ? ^{wd, be_n} ^ bad_dp : ~par_out;
		if (how == 2'h1 && burst) begin
			// Keep asking for a second phase until the target stops it.
			n = 0;
			while (stop_n_in && n < 8) begin
				@(posedge clk_in);
				n++;
			end
			#2;
		end
		irdy_n_out = 1'b1;
		if (burst || how != 2'h1) begin
			frame_n_out = 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the single-phase target.
// Assumes one bus master model and a user side that returns the address XORed with KEY.
`timescale 1ns/1ps
`default_nettype none
module testbench import pci_tgt_pkg::*;;
	localparam logic [31:0] MEM_B = 32'h000d_0000;
	localparam logic [31:0] IO_B = 32'h0000_0300;
	localparam logic [31:0] KEY = 32'h5a5a_a5a5;
	logic sys_clk = 1'b0, rst = 1'b1, frame_n, irdy_n, idsel, m_par;
	logic [31:0] m_ad, ad_bus, d_ad, acc_addr, acc_wdata;
	logic [3:0] m_cbe, acc_be_n;
	logic ad_oe, d_par, par_oe, devsel_n, trdy_n, stop_n, ctl_oe;
	logic perr, serr, strobe, acc_wr, par_bus;
	logic [1:0] acc_space, how;
	logic [31:0] rd, rd_user;
	int n_fail = 0, compares = 0;
	int n_strobe, n_trdy, n_stop, n_abort, n_serr, n_perr, n_oe;

	// ------------------------------------------------------------
	// Clock, shared lines and user side
	// ------------------------------------------------------------
	always #12.5 sys_clk = ~sys_clk;
	assign ad_bus = ad_oe ? d_ad : m_ad;
	assign par_bus = par_oe ? d_par : m_par;
	assign rd_user = acc_addr ^ KEY;

	bus_master i_master (.clk_in(sys_clk), .ad_in(ad_bus),
		.trdy_n_in(trdy_n), .stop_n_in(stop_n), .frame_n_out(frame_n),
		.irdy_n_out(irdy_n), .idsel_out(idsel), .ad_out(m_ad),
		.cbe_n_out(m_cbe), .par_out(m_par));

	pci_target #(.IO_BASE(IO_B), .MEM_BASE(MEM_B)) i_dut (
		.sys_clk_in(sys_clk), .rst_in(rst), .frame_n_in(frame_n),
		.irdy_n_in(irdy_n), .idsel_in(idsel), .ad_in(ad_bus),
		.cbe_n_in(m_cbe), .par_in(par_bus), .rdata_in(rd_user),
		.ad_out(d_ad), .ad_oe_out(ad_oe), .par_out(d_par),
		.par_oe_out(par_oe), .devsel_n_out(devsel_n), .trdy_n_out(trdy_n),
		.stop_n_out(stop_n), .ctl_oe_out(ctl_oe), .perr_int_out(perr),
		.serr_int_out(serr), .acc_strobe_out(strobe),
		.acc_write_out(acc_wr), .acc_space_out(acc_space),
		.acc_addr_out(acc_addr), .acc_be_n_out(acc_be_n),
		.acc_wdata_out(acc_wdata));

	// Event counters that the scenarios clear and then judge.
	always @(posedge sys_clk) begin
		n_strobe += (strobe === 1'b1);
		n_trdy += (trdy_n === 1'b0);
		n_stop += (stop_n === 1'b0);
		n_abort += (stop_n === 1'b0 && devsel_n === 1'b1);
		n_serr += (serr === 1'b1);
		n_perr += (perr === 1'b1);
		n_oe += (ctl_oe === 1'b1 || ad_oe === 1'b1);
	end

	// ------------------------------------------------------------
	// Helpers and scenarios
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic clr();
		{n_strobe, n_trdy, n_stop, n_abort, n_serr, n_perr, n_oe} = '0;
	endtask

	// Every command once, reads and writes in all three spaces.
	task automatic s_cmds();
		logic [3:0] cmds [9] = '{CMD_MEM_RD, CMD_MEM_RD_MULT,
			CMD_MEM_RD_LINE, CMD_MEM_WR, CMD_MEM_WR_INV, CMD_IO_RD,
			CMD_IO_WR, CMD_CFG_RD, CMD_CFG_WR};
		logic [31:0] a;
		logic [1:0] sp;
		for (int i = 0; i < 9; i++) begin
			a = i < 5 ? MEM_B | 32'h40 : i < 7 ? IO_B | 32'h4 : 32'h40;
			sp = i < 5 ? SPACE_MEM : i < 7 ? SPACE_IO : SPACE_CFG;
			clr();
			i_master.run(cmds[i], a, 4'h0, ~a, i > 6, 0, 0, 0, rd, how);
			chk("space", {30'h0, sp}, {30'h0, acc_space});
			chk("write", {31'h0, cmds[i][0]}, {31'h0, acc_wr});
			chk("addr", a, acc_addr);
			if (cmds[i][0]) begin
				chk("wdata", ~a, acc_wdata);
			end else begin
				chk("rdata", a ^ KEY, rd);
				chk("rpar", {31'h0, ^(a ^ KEY)}, {31'h0, d_par});
			end
			i_master.idle(2);
			chk("strobe", 1, n_strobe);
			chk("errs", 0, n_serr + n_perr);
		end
	endtask

	task automatic s_burst();
		clr();
		i_master.run(CMD_MEM_WR, MEM_B | 8, 0, 32'h1234_5678, 0, 0, 0, 1,
			rd, how);
		i_master.idle(3);
		chk("stop", 1, 32'(n_stop > 0));
		chk("trdy", 1, n_trdy);
		chk("strobe", 1, n_strobe);
		chk("wdata", 32'h1234_5678, acc_wdata);
	endtask

	task automatic s_apar();
		clr();
		i_master.run(CMD_MEM_RD, MEM_B, 0, 0, 0, 1, 0, 0, rd, how);
		i_master.idle(3);
		chk("how", 2, {30'h0, how});
		chk("serr", 1, n_serr);
		chk("abort", 1, 32'(n_abort > 0));
		chk("trdy", 0, n_trdy + n_strobe);
	endtask

	// Legal and illegal byte enables for each low address pair.
	task automatic s_be();
		logic [3:0] good [4] = '{4'he, 4'hd, 4'hb, 4'h7};
		logic [3:0] bad [4] = '{4'h1, 4'h0, 4'h9, 4'h3};
		for (int a = 0; a < 4; a++) begin
			for (int b = 0; b < 2; b++) begin
				clr();
				i_master.run(CMD_IO_WR, IO_B | a, b ? bad[a] : good[a],
					32'hcafe_0000 | a, 0, 0, 0, 0, rd, how);
				i_master.idle(3);
				chk("how", b ? 2 : 1, {30'h0, how});
				chk("be_n", b ? bad[a] : good[a], {28'h0, acc_be_n});
				chk("strobe", b ? 0 : 1, n_strobe + n_trdy / 2);
			end
		end
	endtask

	task automatic s_b2b_dpar();
		clr();
		i_master.run(CMD_MEM_WR, MEM_B | 16, 0, 32'h0f0f_0f0f, 0, 0, 1, 0,
			rd, how);
		i_master.run(CMD_MEM_RD, MEM_B | 20, 0, 0, 0, 0, 0, 0, rd, how);
		chk("rdata", (MEM_B | 20) ^ KEY, rd);
		i_master.idle(3);
		chk("strobe", 2, n_strobe);
		chk("perr", 1, n_perr);
		clr();
		i_master.run(CMD_MEM_RD, 32'h1000_0000, 0, 0, 0, 0, 0, 0, rd, how);
		i_master.idle(2);
		chk("miss", 0, n_oe + how);
	endtask

	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence after reset.
	initial begin
		repeat (4) @(posedge sys_clk);
		#2;
		rst = 1'b0;
		s_cmds();
		s_burst();
		s_apar();
		s_be();
		s_b2b_dpar();
		final_report();
	end

	// Watchdog well beyond the roughly 150 cycles the tests need.
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		final_report();
	end
endmodule
`default_nettype wire
